// ===== design/i2cssc_ctrl.sv
// Purpose: serial bus master start/stop control with register port
// Assumes: clk 100 MHz for registers, linkClk drives the bus engine
// Notes: master transmitter only; slave addressing is not implemented,
//        so slave mode is always the not-addressed state
`timescale 1ns/1ps

// Function
// - control bit 7 with two low rate bits selects master serial clock rate
// - enable low floats lines, ignores them, unaddressed slave, forces stop bit 0
// - interface works only when enable set and link select field is 10b
// - start request with idle bus issues START at once
// - busy bus: wait for STOP, then START after half serial period
// - start request as master after a byte gives repeated START
// - start request is accepted at any time, also as addressed slave
// - start bit low means no START or repeated START
// - stop bit as master drives STOP; cleared when STOP seen on bus
// - stop bit in slave mode is internal recovery to unaddressed receiver
// - both bits set: STOP first (bus or internal), then START
// - stop bit low means no STOP generated
// - interrupt flag set on reportable state, clock held low until cleared
// - after START the flag sets and status reads 08h
module i2cssc_ctrl
   import i2cssc_pkg::*;
#(
   parameter int HALF_STD_CYC = STD_HALF_CYC,
   parameter int HALF_FAST_CYC = FAST_HALF_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic linkClk,
   input wire logic [BUS_ADDR_W-1:0] addr,
   input wire logic [7:0] wrData,
   input wire logic wrEn,
   input wire logic rdEn,
   output logic [7:0] rdData,
   input wire logic sclIn,
   output logic sclOut,
   output logic sclOe,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe
);

   // the slowest divider is eight times the standard half period
   if (HALF_STD_CYC < 2 || HALF_FAST_CYC < 2 || HALF_STD_CYC * 8 >= 2 ** CNT_W
       || HALF_FAST_CYC * 8 >= 2 ** CNT_W) begin : gBadHalf
      $error("half period counts out of range for the counter");
   end

   // ----------------------------------------------------------------
   // crossings
   // ----------------------------------------------------------------
   i2cssc_xing_if #(.WIDTH($bits(i2cssc_tolink_s))) toLinkIf ();
   i2cssc_xing_if #(.WIDTH($bits(i2cssc_tocpu_s))) toCpuIf ();
   i2cssc_xing_if #(.WIDTH(2)) pinIf ();

   i2cssc_sync #(.WIDTH($bits(i2cssc_tolink_s))) uSyncToLink (
      .dstClk(linkClk),
      .rst_n(rst_n),
      .xing(toLinkIf)
   );

   i2cssc_sync #(.WIDTH($bits(i2cssc_tocpu_s))) uSyncToCpu (
      .dstClk(clk),
      .rst_n(rst_n),
      .xing(toCpuIf)
   );

   i2cssc_sync #(.WIDTH(2)) uSyncPins (
      .dstClk(linkClk),
      .rst_n(rst_n),
      .xing(pinIf)
   );

   // ----------------------------------------------------------------
   // register side (clk)
   // ----------------------------------------------------------------
   logic [7:0] ctl_reg;
   logic [7:0] status_reg;
   logic [7:0] txData_reg;
   logic [1:0] linkSel_reg;
   logic [7:0] rdData_reg;
   i2cssc_tolink_s toLink;
   i2cssc_tocpu_s cpuSeen;
   i2cssc_tocpu_s cpuD1_reg;
   i2cssc_tocpu_s cpuD2_reg;
   logic enActive;
   logic startEv;
   logic rstartEv;
   logic byteEv;
   logic stopEv;
   logic wrCtl;
   logic slaveRecover;

   assign cpuSeen = i2cssc_tocpu_s'(toCpuIf.dstBits);
   assign enActive = ctl_reg[CTL_ENABLE] && (linkSel_reg == LINK_SEL_THIS);
   assign wrCtl = wrEn && (addr == OFS_CONTROL);
   // stop written while not master never reaches the bus
   assign slaveRecover = wrCtl && wrData[CTL_STOP] && !cpuSeen.master;

   // events are acted on one cycle late so the ack level has settled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cpuD1_reg <= '0;
         cpuD2_reg <= '0;
      end else begin
         cpuD1_reg <= cpuSeen;
         cpuD2_reg <= cpuD1_reg;
      end
   end

   assign startEv = cpuD1_reg.startTgl ^ cpuD2_reg.startTgl;
   assign rstartEv = cpuD1_reg.rstartTgl ^ cpuD2_reg.rstartTgl;
   assign byteEv = cpuD1_reg.byteTgl ^ cpuD2_reg.byteTgl;
   assign stopEv = cpuD1_reg.stopTgl ^ cpuD2_reg.stopTgl;

   // control register; hardware set of the flag wins over a firmware clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_reg <= CTL_RESET;
      end else begin
         if (wrCtl) begin
            ctl_reg <= wrData;
            if (slaveRecover) begin
               ctl_reg[CTL_STOP] <= 1'b0;
            end
         end
         if (enActive && (startEv || rstartEv || byteEv)) begin
            ctl_reg[CTL_SI] <= 1'b1;
         end
         if (stopEv && !(wrCtl && wrData[CTL_STOP] && cpuSeen.master)) begin
            ctl_reg[CTL_STOP] <= 1'b0;
         end
         if (!ctl_reg[CTL_ENABLE] || (wrCtl && !wrData[CTL_ENABLE])) begin
            ctl_reg[CTL_STOP] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_reg <= ST_NONE;
      end else if (!enActive || slaveRecover) begin
         status_reg <= ST_NONE;
      end else if (startEv) begin
         status_reg <= ST_START;
      end else if (rstartEv) begin
         status_reg <= ST_RSTART;
      end else if (byteEv) begin
         status_reg <= cpuSeen.ack ? ST_TX_ACK : ST_TX_NACK;
      end else if (stopEv && !cpuSeen.master) begin
         status_reg <= ST_NONE;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txData_reg <= DATA_RESET;
         linkSel_reg <= LINK_SEL_RESET;
      end else if (wrEn) begin
         if (addr == OFS_DATA) begin
            txData_reg <= wrData;
         end
         if (addr == OFS_LINK_SEL) begin
            linkSel_reg <= wrData[1:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdData_reg <= 8'h00;
      end else if (rdEn) begin
         case (addr)
            OFS_CONTROL: rdData_reg <= ctl_reg;
            OFS_STATUS: rdData_reg <= status_reg;
            OFS_DATA: rdData_reg <= txData_reg;
            OFS_LINK_SEL: rdData_reg <= {6'h00, linkSel_reg};
            default: rdData_reg <= 8'h00;
         endcase
      end else begin
         rdData_reg <= 8'h00;
      end
   end

   assign rdData = rdData_reg;

   always_comb begin
      toLink.txData = txData_reg;
      toLink.rate = {ctl_reg[CTL_RATE_HIGH], ctl_reg[CTL_RATE_LOW_MSB:0]};
      toLink.si = ctl_reg[CTL_SI];
      toLink.stopReq = ctl_reg[CTL_STOP];
      // a pending stop is finished before any start is issued
      toLink.startCmd = ctl_reg[CTL_START] && !ctl_reg[CTL_STOP];
      toLink.enable = enActive;
   end

   assign toLinkIf.srcBits = toLink;

   // ----------------------------------------------------------------
   // link side (linkClk)
   // ----------------------------------------------------------------
   i2cssc_tolink_s lnk;
   i2cssc_link_e state_reg;
   logic sclS;
   logic sdaS;
   logic sdaD_reg;
   logic busy_reg;
   logic stopTgl_reg;
   logic startTgl_reg;
   logic rstartTgl_reg;
   logic byteTgl_reg;
   logic ack_reg;
   logic master_reg;
   logic restart_reg;
   logic bytesDone_reg;
   logic sclOe_reg;
   logic sdaOe_reg;
   logic [7:0] shift_reg;
   logic [3:0] bitIdx_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] halfCnt;
   logic halfDone;
   logic siD_reg;

   assign pinIf.srcBits = {sclIn, sdaIn};
   assign lnk = i2cssc_tolink_s'(toLinkIf.dstBits);
   assign sclS = pinIf.dstBits[1];
   assign sdaS = pinIf.dstBits[0];

   // rate_select_high picks fast base, the low bits divide by 1, 2, 4 or 8
   always_comb begin
      halfCnt = lnk.rate[2] ? CNT_W'(HALF_FAST_CYC) : CNT_W'(HALF_STD_CYC);
      halfCnt = halfCnt << lnk.rate[1:0];
   end

   assign halfDone = (cnt_reg == halfCnt - CNT_W'(1));

   // bus monitor: busy between START and STOP; lines ignored when disabled
   always_ff @(posedge linkClk or negedge rst_n) begin
      if (!rst_n) begin
         sdaD_reg <= 1'b1;
         busy_reg <= 1'b0;
         stopTgl_reg <= 1'b0;
      end else if (!lnk.enable) begin
         sdaD_reg <= 1'b1;
         busy_reg <= 1'b0;
      end else begin
         sdaD_reg <= sdaS;
         if (sclS && sdaD_reg && !sdaS) begin
            busy_reg <= 1'b1;
         end else if (sclS && !sdaD_reg && sdaS) begin
            busy_reg <= 1'b0;
            stopTgl_reg <= ~stopTgl_reg;
         end
      end
   end

   // a flag clear is acted on after two low samples, so the stop, start and
   // rate bits of the same control write have crossed as well
   always_ff @(posedge linkClk or negedge rst_n) begin
      if (!rst_n) begin
         siD_reg <= 1'b0;
      end else begin
         siD_reg <= lnk.si;
      end
   end

   // bus engine
   always_ff @(posedge linkClk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= L_IDLE;
         cnt_reg <= '0;
         sclOe_reg <= 1'b0;
         sdaOe_reg <= 1'b0;
         shift_reg <= 8'h00;
         bitIdx_reg <= 4'h0;
         master_reg <= 1'b0;
         restart_reg <= 1'b0;
         bytesDone_reg <= 1'b0;
         ack_reg <= 1'b0;
         startTgl_reg <= 1'b0;
         rstartTgl_reg <= 1'b0;
         byteTgl_reg <= 1'b0;
      end else if (!lnk.enable) begin
         state_reg <= L_IDLE;
         cnt_reg <= '0;
         sclOe_reg <= 1'b0;
         sdaOe_reg <= 1'b0;
         master_reg <= 1'b0;
         bytesDone_reg <= 1'b0;
      end else begin
         cnt_reg <= halfDone ? '0 : cnt_reg + CNT_W'(1);
         case (state_reg)
            L_IDLE: begin
               cnt_reg <= '0;
               restart_reg <= 1'b0;
               if (lnk.startCmd) begin
                  master_reg <= 1'b1;
                  if (!busy_reg && sclS && sdaS) begin
                     sdaOe_reg <= 1'b1;
                     state_reg <= L_START;
                  end else begin
                     state_reg <= L_WAIT_FREE;
                  end
               end
            end
            L_WAIT_FREE: begin
               if (!lnk.startCmd) begin
                  master_reg <= 1'b0;
                  state_reg <= L_IDLE;
               end else if (busy_reg) begin
                  cnt_reg <= '0;
               end else if (halfDone) begin
                  sdaOe_reg <= 1'b1;
                  state_reg <= L_START;
               end
            end
            L_START: begin
               if (halfDone) begin
                  sclOe_reg <= 1'b1;
                  bytesDone_reg <= 1'b0;
                  if (restart_reg) begin
                     rstartTgl_reg <= ~rstartTgl_reg;
                  end else begin
                     startTgl_reg <= ~startTgl_reg;
                  end
                  state_reg <= L_HOLD_SET;
               end
            end
            L_HOLD_SET: begin
               cnt_reg <= '0;
               if (lnk.si) begin
                  state_reg <= L_HOLD;
               end
            end
            L_HOLD: begin
               // clock stays low until firmware clears the flag
               cnt_reg <= '0;
               if (!lnk.si && !siD_reg) begin
                  if (lnk.stopReq) begin
                     sdaOe_reg <= 1'b1;
                     state_reg <= L_STOP_LOW;
                  end else if (lnk.startCmd && bytesDone_reg) begin
                     sdaOe_reg <= 1'b0;
                     restart_reg <= 1'b1;
                     state_reg <= L_RS_LOW;
                  end else begin
                     shift_reg <= lnk.txData;
                     sdaOe_reg <= ~lnk.txData[7];
                     bitIdx_reg <= 4'h0;
                     state_reg <= L_BIT_LOW;
                  end
               end
            end
            L_BIT_LOW: begin
               if (halfDone) begin
                  sclOe_reg <= 1'b0;
                  state_reg <= L_BIT_HIGH;
               end
            end
            L_BIT_HIGH: begin
               // a slave holding the clock low stretches the high phase
               if (!sclS) begin
                  cnt_reg <= '0;
               end else if (halfDone) begin
                  sclOe_reg <= 1'b1;
                  if (bitIdx_reg == 4'(BIT_ACK)) begin
                     ack_reg <= !sdaS;
                     byteTgl_reg <= ~byteTgl_reg;
                     bytesDone_reg <= 1'b1;
                     sdaOe_reg <= 1'b0;
                     state_reg <= L_HOLD_SET;
                  end else begin
                     shift_reg <= {shift_reg[6:0], 1'b1};
                     sdaOe_reg <= ~shift_reg[6];
                     bitIdx_reg <= bitIdx_reg + 4'h1;
                     state_reg <= L_BIT_LOW;
                  end
               end
            end
            L_RS_LOW: begin
               if (halfDone) begin
                  sclOe_reg <= 1'b0;
                  state_reg <= L_RS_HIGH;
               end
            end
            L_RS_HIGH: begin
               if (!sclS) begin
                  cnt_reg <= '0;
               end else if (halfDone) begin
                  sdaOe_reg <= 1'b1;
                  state_reg <= L_START;
               end
            end
            L_STOP_LOW: begin
               if (halfDone) begin
                  sclOe_reg <= 1'b0;
                  state_reg <= L_STOP_HIGH;
               end
            end
            L_STOP_HIGH: begin
               if (!sclS) begin
                  cnt_reg <= '0;
               end else if (halfDone) begin
                  sdaOe_reg <= 1'b0;
                  master_reg <= 1'b0;
                  state_reg <= L_IDLE;
               end
            end
            default: begin
               state_reg <= L_IDLE;
               sclOe_reg <= 1'b0;
               sdaOe_reg <= 1'b0;
            end
         endcase
      end
   end

   assign toCpuIf.srcBits = {master_reg, ack_reg, stopTgl_reg, byteTgl_reg,
                             rstartTgl_reg, startTgl_reg};

   // ----------------------------------------------------------------
   // pins: open drain, only low is ever driven
   // ----------------------------------------------------------------
   logic lowDrive_reg;

   always_ff @(posedge linkClk or negedge rst_n) begin
      if (!rst_n) begin
         lowDrive_reg <= 1'b0;
      end else begin
         lowDrive_reg <= 1'b0;
      end
   end

   assign sclOut = lowDrive_reg;
   assign sdaOut = lowDrive_reg;
   assign sclOe = sclOe_reg;
   assign sdaOe = sdaOe_reg;

endmodule

// ===== design/i2cssc_pkg.sv
// Purpose: shared constants and types of the serial bus start/stop controller
// Assumes: system clock 100 MHz, link clock period 15 ns
// Notes: offsets are register indices on the plain register port

package i2cssc_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int BUS_ADDR_W = 4;
   localparam logic [BUS_ADDR_W-1:0] OFS_CONTROL = 4'h0;
   localparam logic [BUS_ADDR_W-1:0] OFS_STATUS = 4'h1;
   localparam logic [BUS_ADDR_W-1:0] OFS_DATA = 4'h2;
   localparam logic [BUS_ADDR_W-1:0] OFS_LINK_SEL = 4'h3;

   // serial_bus_control fields
   localparam int CTL_RATE_HIGH = 7;
   localparam int CTL_ENABLE = 6;
   localparam int CTL_START = 5;
   localparam int CTL_STOP = 4;
   localparam int CTL_SI = 3;
   localparam int CTL_ACK = 2;
   localparam int CTL_RATE_LOW_MSB = 1;
   localparam logic [7:0] CTL_RESET = 8'h00;

   localparam logic [1:0] LINK_SEL_THIS = 2'h2;
   localparam logic [1:0] LINK_SEL_RESET = 2'h0;
   localparam logic [7:0] DATA_RESET = 8'h00;

   // serial_bus_status codes
   localparam logic [7:0] ST_START = 8'h08;
   localparam logic [7:0] ST_RSTART = 8'h10;
   localparam logic [7:0] ST_TX_ACK = 8'h28;
   localparam logic [7:0] ST_TX_NACK = 8'h30;
   localparam logic [7:0] ST_NONE = 8'hF8;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int LINK_PERIOD_PS = 15000;
   localparam int STD_HALF_PS = 5000000;
   localparam int FAST_HALF_PS = 1250000;
   localparam int STD_HALF_CYC = (STD_HALF_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
   localparam int FAST_HALF_CYC = (FAST_HALF_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
   localparam int CNT_W = 12;
   localparam int BIT_ACK = 8;

   // ----------------------------------------------------------------
   // crossing bundles
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] txData;
      logic [2:0] rate;
      logic si;
      logic stopReq;
      logic startCmd;
      logic enable;
   } i2cssc_tolink_s;

   typedef struct packed {
      logic master;
      logic ack;
      logic stopTgl;
      logic byteTgl;
      logic rstartTgl;
      logic startTgl;
   } i2cssc_tocpu_s;

   typedef enum logic [3:0] {
      L_IDLE = 4'h0,
      L_WAIT_FREE = 4'h1,
      L_START = 4'h2,
      L_HOLD_SET = 4'h3,
      L_HOLD = 4'h4,
      L_BIT_LOW = 4'h5,
      L_BIT_HIGH = 4'h6,
      L_RS_LOW = 4'h7,
      L_RS_HIGH = 4'h8,
      L_STOP_LOW = 4'h9,
      L_STOP_HIGH = 4'hA
   } i2cssc_link_e;

endpackage

// ===== design/i2cssc_sync.sv
// Purpose: two-flop synchroniser for a bundle of bits
// Assumes: each bit is a level or a toggle, never a one-cycle pulse
// Notes: multi-bit words must be stable while they are sampled
`timescale 1ns/1ps

module i2cssc_sync #(
   parameter int WIDTH = 1
) (
   input wire logic dstClk,
   input wire logic rst_n,
   i2cssc_xing_if.sync xing
);

   logic [WIDTH-1:0] stage1Reg;
   logic [WIDTH-1:0] stage2Reg;

   if (WIDTH < 1) begin : gBadWidth
      $error("synchroniser width must be at least one");
   end

   // ----------------------------------------------------------------
   // first stage is read by the second stage only
   // ----------------------------------------------------------------
   always_ff @(posedge dstClk or negedge rst_n) begin
      if (!rst_n) begin
         stage1Reg <= '0;
         stage2Reg <= '0;
      end else begin
         stage1Reg <= xing.srcBits;
         stage2Reg <= stage1Reg;
      end
   end

   assign xing.dstBits = stage2Reg;

endmodule

// ===== design/i2cssc_xing_if.sv
// Purpose: carries a bundle of levels from one clock domain to another
// Assumes: source bits are quasi-static or toggle-coded
// Notes: the synchroniser drives dstBits
`timescale 1ns/1ps

interface i2cssc_xing_if #(parameter int WIDTH = 1);
   logic [WIDTH-1:0] srcBits;
   logic [WIDTH-1:0] dstBits;

   modport sync (input srcBits, output dstBits);
   modport user (output srcBits, input dstBits);
endinterface

// ===== verif/i2c_master_start_stop_control_test.sv
// Purpose: self-checking bench of the start/stop controller
// Assumes: shortened half periods of 4 and 2 link clocks
// Notes: lines resolve as wired-and with pull-ups
`timescale 1ns/1ps

module i2c_master_start_stop_control_test;
   import i2cssc_pkg::*;
   localparam int HS = 4;
   localparam int HF = 2;
   logic clk = 0;
   logic linkClk = 0;
   logic rst_n = 0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wrData = 8'h00;
   logic wrEn = 0;
   logic rdEn = 0;
   logic ackEn = 1;
   logic hog = 0;
   logic [7:0] rdData;
   logic sclOe;
   logic sdaOe;
   logic sclO;
   logic sdaO;
   logic slvPull;
   logic [7:0] rxByte;
   logic scl;
   logic sda;
   logic prevSda = 0;
   logic [7:0] v;
   logic [7:0] sentQ[$];
   logic [7:0] rates[3] = '{8'h00, 8'h80, 8'h82};
   logic [7:0] rstVal[5] = '{CTL_RESET, ST_NONE, DATA_RESET, 8'h00, 8'h00};
   int error_cnt = 0;
   int tests_run = 0;
   int starts = 0;
   int stops = 0;
   int lowRun = 0;
   int minLow = 255;

   // the driven values take part, so a pin that drives high breaks the bus
   assign scl = sclOe ? sclO : 1'b1;
   assign sda = (sdaOe ? sdaO : 1'b1) && !slvPull;

   i2cssc_ctrl #(.HALF_STD_CYC(HS), .HALF_FAST_CYC(HF)) i2cssc_ctrl_inst (.clk, .rst_n,
      .linkClk, .addr, .wrData, .wrEn, .rdEn, .rdData, .sclIn(scl), .sclOut(sclO), .sclOe,
      .sdaIn(sda), .sdaOut(sdaO), .sdaOe);
   i2cssc_slave_model i2cssc_slave_model_inst (.scl, .sda, .ackEn, .hog, .sdaPull(slvPull),
      .rxByte);

   initial begin
      forever #5 clk = ~clk;
   end
   initial begin
      #3;
      forever #7.5 linkClk = ~linkClk;
   end
   // sampled away from the edge that updates the enables
   always @(negedge linkClk) begin
      if (sdaOe && !prevSda && !sclOe) starts++;
      if (!sdaOe && prevSda && !sclOe) stops++;
      prevSda = sdaOe;
      if (sclOe) lowRun++;
      else begin
         if (lowRun > 0 && lowRun < minLow) minLow = lowRun;
         lowRun = 0;
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrEn <= 1'b1;
      @(posedge clk);
      wrEn <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge clk);
      rdEn <= 1'b0;
      #1 d = rdData;
   endtask
   // bounded poll of control bits under a mask
   task automatic pollCtl(input logic [7:0] m, input logic [7:0] want);
      int n = 0;
      rd(OFS_CONTROL, v);
      while ((v & m) !== want && n < 800) begin
         rd(OFS_CONTROL, v);
         n++;
      end
      chk(v & m, want);
   endtask
   task automatic stat(input logic [7:0] exp);
      rd(OFS_STATUS, v);
      chk(v, exp);
   endtask
   task automatic summarize;
      $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   initial begin
      #200000;
      error_cnt++;
      summarize();
   end

   initial begin
      int h;
      void'($urandom(36));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rstVal[i]) begin
         rd(4'(i), v);
         chk(v, rstVal[i]);
      end
      wr(4'hF, 8'hFF);
      rd(4'hF, v);
      chk(v, 8'h00);
      wr(OFS_CONTROL, 8'h60);
      repeat (60) @(posedge clk);
      stat(ST_NONE);
      chk(8'(starts), 8'h00);
      wr(OFS_CONTROL, 8'h40);
      wr(OFS_LINK_SEL, {6'h00, LINK_SEL_THIS});
      hog <= 1'b1;
      repeat (20) @(posedge clk);
      wr(OFS_CONTROL, 8'h60);
      repeat (80) @(posedge clk);
      chk(8'(starts), 8'h00);
      hog <= 1'b0;
      pollCtl(8'h08, 8'h08);
      stat(ST_START);
      chk(8'(starts), 8'h01);
      foreach (rates[i]) begin
         h = (rates[i][7] ? HF : HS) << rates[i][1:0];
         sentQ.push_back(8'($urandom));
         wr(OFS_DATA, sentQ[$]);
         minLow = 255;
         wr(OFS_CONTROL, 8'h40 | rates[i]);
         pollCtl(8'h08, 8'h08);
         stat(ST_TX_ACK);
         chk(8'(sclOe), 8'h01);
         chk(rxByte, sentQ.pop_front());
         chk(8'(minLow >= h && minLow <= h + 2), 8'h01);
      end
      chk(8'(starts), 8'h01);
      wr(OFS_CONTROL, 8'h60);
      pollCtl(8'h08, 8'h08);
      stat(ST_RSTART);
      ackEn <= 1'b0;
      wr(OFS_DATA, 8'($urandom));
      wr(OFS_CONTROL, 8'h40);
      pollCtl(8'h08, 8'h08);
      stat(ST_TX_NACK);
      ackEn <= 1'b1;
      wr(OFS_CONTROL, 8'h50);
      pollCtl(8'h10, 8'h00);
      chk(8'(stops), 8'h01);
      chk({6'h00, scl, sda}, 8'h03);
      wr(OFS_CONTROL, 8'h70);
      rd(OFS_CONTROL, v);
      chk(v & 8'h10, 8'h00);
      pollCtl(8'h08, 8'h08);
      stat(ST_START);
      chk(8'(stops), 8'h01);
      wr(OFS_CONTROL, 8'h10);
      rd(OFS_CONTROL, v);
      chk(v, 8'h00);
      repeat (20) @(posedge clk);
      chk({6'h00, sclOe, sdaOe}, 8'h00);
      summarize();
   end
endmodule

// ===== verif/i2cssc_ctrl_chk.sv
// Purpose: pin-level checks of the start/stop controller
// Assumes: register shadows follow the writes seen at the port
// Notes: engine state is inferred from the drive enables
`timescale 1ns/1ps

module i2cssc_ctrl_chk
   import i2cssc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic linkClk,
   input wire logic [BUS_ADDR_W-1:0] addr,
   input wire logic [7:0] wrData,
   input wire logic wrEn,
   input wire logic rdEn,
   input wire logic [7:0] rdData,
   input wire logic sclOe,
   input wire logic sdaOe
);
   logic [7:0] ctlSh;
   logic [1:0] selSh;
   logic [3:0] offCnt;
   logic enCfg;

   assign enCfg = ctlSh[CTL_ENABLE] && selSh == LINK_SEL_THIS;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) ctlSh <= CTL_RESET;
      else if (wrEn && addr == OFS_CONTROL) ctlSh <= wrData;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) selSh <= LINK_SEL_RESET;
      else if (wrEn && addr == OFS_LINK_SEL) selSh <= wrData[1:0];
   end

   // saturates so a status read long after disabling can be judged
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) offCnt <= 4'h0;
      else if (enCfg) offCnt <= 4'h0;
      else if (offCnt != 4'hF) offCnt <= offCnt + 4'h1;
   end

   chk_rd_idle: assert property (@(posedge clk) disable iff (!rst_n)
      !rdEn |=> rdData == 8'h00) else $error("read data not idle");
   chk_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
      rdEn && addr > OFS_LINK_SEL |=> rdData == 8'h00) else $error("unmapped read");
   chk_ctl_keep: assert property (@(posedge clk) disable iff (!rst_n)
      rdEn && addr == OFS_CONTROL |=> rdData[7:6] == ctlSh[7:6] && rdData[2:0] == ctlSh[2:0])
      else $error("control bits lost");
   chk_off_stop: assert property (@(posedge clk) disable iff (!rst_n)
      rdEn && addr == OFS_CONTROL && !ctlSh[CTL_ENABLE] |=> !rdData[CTL_STOP])
      else $error("stop bit not forced");
   chk_off_status: assert property (@(posedge clk) disable iff (!rst_n)
      rdEn && addr == OFS_STATUS && offCnt == 4'hF |=> rdData == ST_NONE)
      else $error("status not idle");
   chk_link_sel: assert property (@(posedge clk) disable iff (!rst_n)
      rdEn && addr == OFS_LINK_SEL |=> rdData == {6'h00, selSh}) else $error("link select");
   chk_off_float: assert property (@(posedge linkClk) disable iff (!rst_n)
      !enCfg [*8] |-> !sclOe && !sdaOe) else $error("lines driven while off");
   chk_start_gate: assert property (@(posedge linkClk) disable iff (!rst_n)
      $rose(sdaOe) && !sclOe |-> ctlSh[CTL_START]) else $error("start without request");
   chk_stop_gate: assert property (@(posedge linkClk) disable iff (!rst_n)
      $fell(sdaOe) && !sclOe && enCfg |-> ctlSh[CTL_STOP]) else $error("stop without request");
endmodule

bind i2cssc_ctrl i2cssc_ctrl_chk chk_inst (.clk, .rst_n, .linkClk, .addr, .wrData, .wrEn,
   .rdEn, .rdData, .sclOe, .sdaOe);

// ===== verif/i2cssc_slave_model.sv
// Purpose: behavioural slave receiver on the serial bus
// Assumes: both lines are open drain with pull-ups
// Notes: hog pulls data low to play a foreign master
`timescale 1ns/1ps

module i2cssc_slave_model (
   input wire logic scl,
   input wire logic sda,
   input wire logic ackEn,
   input wire logic hog,
   output logic sdaPull,
   output logic [7:0] rxByte
);
   int bitCnt = 0;
   logic ackDrv = 1'b0;

   assign sdaPull = ackDrv || hog;
   // data falling with the clock high frames a new byte
   always @(negedge sda) begin
      if (scl) bitCnt = 0;
   end
   always @(posedge scl) begin
      if (bitCnt < 8) rxByte = {rxByte[6:0], sda};
      bitCnt++;
   end
   // ninth clock is the acknowledge slot, released at its falling edge
   always @(negedge scl) begin
      ackDrv = bitCnt == 8 && ackEn;
      if (bitCnt == 9) bitCnt = 0;
   end
endmodule
